// ==== rpu_attr_decode.sv ====
/*
  Decodes one memory-type slot byte into type, cacheability and hints.
  Assumes the slot byte is already selected by the caller.
*/
`timescale 1ns/1ps
`include "rpu_cfg.svh"
module rpu_attr_decode (
   input  logic [7:0]         slot,
   output logic               dev,
   output logic [1:0]         dev_kind,
   output rpu_pkg::rpu_cache_t inner,
   output rpu_pkg::rpu_cache_t outer,
   output logic [1:0]         inner_alloc,
   output logic [1:0]         outer_alloc
);
   import rpu_pkg::*;

   function automatic rpu_cache_t nib_cache(input logic [3:0] nib);
      if (nib == `RPU_NC_NIBBLE || nib == `RPU_DEV_NIBBLE)
         return RPU_NC;
      return nib[2] ? RPU_WB : RPU_WT;
   endfunction : nib_cache

   always_comb
   begin
      dev         = (slot[7:4] == `RPU_DEV_NIBBLE);
      dev_kind    = dev ? slot[3:2] : 2'h0;
      inner       = dev ? RPU_NC : nib_cache(slot[3:0]);
      outer       = dev ? RPU_NC : nib_cache(slot[7:4]);
      inner_alloc = (inner == RPU_NC) ? 2'h0 : slot[1:0];
      outer_alloc = (outer == RPU_NC) ? 2'h0 : slot[5:4];
   end

endmodule : rpu_attr_decode

// ==== rpu_cfg.svh ====
/*
  Register offsets, field positions, reset values and fixed attribute
  bytes for the region protection unit.
  Assumes it is included by bare name from the design files.
*/
`ifndef RPU_CFG_SVH
`define RPU_CFG_SVH

`define RPU_OFF_CTRL        12'h000
`define RPU_OFF_MTI0        12'h004
`define RPU_OFF_MTI1        12'h008
`define RPU_OFF_HMTI0       12'h00C
`define RPU_OFF_HMTI1       12'h010
`define RPU_OFF_STATUS      12'h014
`define RPU_OFF_FADDR       12'h018
`define RPU_PAGE_KREG       4'h1
`define RPU_PAGE_HREG       4'h2

`define RPU_CTRL_K_EN       0
`define RPU_CTRL_H_EN       1
`define RPU_CTRL_S2_EN      2
`define RPU_CTRL_K_BG       3
`define RPU_CTRL_H_BG       4

`define RPU_BAR_NOEXEC      0
`define RPU_BAR_PERM_LO     1
`define RPU_BAR_PERM_HI     2
`define RPU_BAR_DOM_LO      3
`define RPU_BAR_DOM_HI      4
`define RPU_LAR_EN          0
`define RPU_LAR_IDX_LO      1
`define RPU_LAR_IDX_HI      3
`define RPU_ADDR_LO         6

`define RPU_GRAN_ZERO       6'h00
`define RPU_GRAN_ONES       6'h3F

`define RPU_RST_WORD        32'h0000_0000
`define RPU_DFLT_NORMAL     8'h44
`define RPU_DFLT_DEV_E      8'h04
`define RPU_DFLT_DEV_NE     8'h00
`define RPU_NC_NIBBLE       4'h4
`define RPU_DEV_NIBBLE      4'h0
`define RPU_SHARE_NON       2'h0
`define RPU_SHARE_OUTER     2'h2
`define RPU_SHARE_INNER     2'h3

`endif

// ==== rpu_core_model.sv ====
/* Core pipeline model: turns bench commands into one-cycle core requests.
   Assumes commands change just after a rising edge. */
`timescale 1ns/1ps
module rpu_core_model (
   input  wire logic          clock,
   input  wire logic          go,
   input  wire logic [31:0]   go_addr,
   input  wire logic [1:0]    go_tier,
   input  wire logic          go_write,
   input  wire logic          go_fetch,
   output rpu_pkg::rpu_tier_t req_tier = rpu_pkg::RPU_UNPRIV,
   output logic               req_valid = 1'b0,
   output logic [31:0]        req_addr = 32'h0000_0000,
   output logic               req_write = 1'b0,
   output logic               req_fetch = 1'b0
);
   import rpu_pkg::*;
   // Idle address, write and fetch lines toggle so stale values never pass for requests
   always @(posedge clock)
   begin
      req_valid <= go;
      req_tier  <= rpu_tier_t'(go_tier);
      req_addr  <= go ? go_addr : ~req_addr;
      req_write <= go ? go_write : ~req_write;
      req_fetch <= go ? go_fetch : ~req_fetch;
   end
endmodule : rpu_core_model

// ==== rpu_pkg.sv ====
/*
  Types shared by the region protection unit files.
  Assumes nothing of its surroundings.
*/
package rpu_pkg;

   typedef enum logic [1:0] {
      RPU_NC = 2'h0,
      RPU_WT = 2'h1,
      RPU_WB = 2'h2
   } rpu_cache_t;

   typedef enum logic [1:0] {
      RPU_UNPRIV = 2'h0,
      RPU_KERNEL = 2'h1,
      RPU_HYP    = 2'h2
   } rpu_tier_t;

   typedef struct packed {
      logic       dev;
      logic [1:0] dev_kind;
      rpu_cache_t inner;
      rpu_cache_t outer;
      logic [1:0] inner_alloc;
      logic [1:0] outer_alloc;
      logic [1:0] share;
   } rpu_attr_t;

endpackage : rpu_pkg

// ==== rpu_region_match.sv ====
/*
  Parallel base/limit compare over one set of protection regions.
  Assumes regions do not overlap; the lowest hit index is reported.
*/
`timescale 1ns/1ps
`include "rpu_cfg.svh"
module rpu_region_match #(
   parameter int NREG = 8,
   parameter int IW   = 3
) (
   input  logic [31:0]           addr,
   input  logic [NREG-1:0][31:0] base,
   input  logic [NREG-1:0][31:0] limit,
   output logic                  hit,
   output logic [IW-1:0]         idx
);
   import rpu_pkg::*;

   logic [NREG-1:0] in_rgn;

   genvar g;
   generate
      for (g = 0; g < NREG; g++)
      begin : g_cmp
         assign in_rgn[g] = limit[g][`RPU_LAR_EN]
            & (addr >= {base[g][31:`RPU_ADDR_LO], `RPU_GRAN_ZERO})
            & (addr <= {limit[g][31:`RPU_ADDR_LO], `RPU_GRAN_ONES});
      end
   endgenerate

   always_comb
   begin
      hit = |in_rgn;
      idx = '0;
      for (int i = NREG - 1; i >= 0; i--)
      begin
         if (in_rgn[i])
            idx = IW'(i);
      end
   end

endmodule : rpu_region_match

// ==== rpu_top.sv ====
/*
  Region protection unit: Avalon-MM register slave, kernel-tier and
  hypervisor-tier region sets, two-stage permission and attribute check.
  Assumes core requests are synchronous to clock and answered one cycle later.
*/
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "rpu_cfg.svh"
module rpu_top #(
   parameter int NREG = 8
) (
   input  logic                clock,
   input  logic                rst_b,
   input  logic [11:0]         avs_address,
   input  logic                avs_read,
   input  logic                avs_write,
   input  logic [31:0]         avs_writedata,
   input  logic [3:0]          avs_byteenable,
   output logic [31:0]         avs_readdata,
   output logic                avs_waitrequest,
   input  logic                req_valid,
   input  logic [31:0]         req_addr,
   input  rpu_pkg::rpu_tier_t  req_tier,
   input  logic                req_write,
   input  logic                req_fetch,
   output logic                resp_valid,
   output logic [31:0]         resp_paddr,
   output logic                resp_fault_s1,
   output logic                resp_fault_s2,
   output logic                resp_background,
   output logic                resp_device,
   output logic [1:0]          resp_dev_kind,
   output rpu_pkg::rpu_cache_t resp_inner,
   output rpu_pkg::rpu_cache_t resp_outer,
   output logic [1:0]          resp_inner_alloc,
   output logic [1:0]          resp_outer_alloc,
   output logic [1:0]          resp_share
);
   import rpu_pkg::*;

   localparam int IW = (NREG > 1) ? $clog2(NREG) : 1;

   logic                 rst_meta_b;
   logic                 rst_sync_b;
   logic [31:0]          ctrl_reg;
   logic [31:0]          mem_type_indirect_reg [2];
   logic [31:0]          hyp_mem_type_indirect_reg [2];
   logic [NREG-1:0][31:0] region_base_reg;
   logic [NREG-1:0][31:0] region_limit_reg;
   logic [NREG-1:0][31:0] hyp_region_base_reg;
   logic [NREG-1:0][31:0] hyp_region_limit_reg;
   logic [31:0]          fault_addr;
   logic [31:0]          next_ctrl_reg;
   logic [31:0]          next_mti [2];
   logic [31:0]          next_hmti [2];
   logic [NREG-1:0][31:0] next_kbar;
   logic [NREG-1:0][31:0] next_klar;
   logic [NREG-1:0][31:0] next_hbar;
   logic [NREG-1:0][31:0] next_hlar;
   logic [31:0]          next_readdata;
   logic                 next_waitrequest;
   logic [31:0]          next_fault_addr;
   logic                 bus_req;
   logic                 bus_take;
   logic [4:0]           rgn_sel;
   logic                 rgn_ok;
   logic [31:0]          rd_word;
   logic                 k_hit;
   logic                 h_hit;
   logic [IW-1:0]        k_idx;
   logic [IW-1:0]        h_idx;
   logic [31:0]          k_bar;
   logic [31:0]          k_lar;
   logic [31:0]          h_bar;
   logic [31:0]          h_lar;
   logic [7:0]           k_slot;
   logic [7:0]           h_slot;
   logic [7:0]           d_slot;
   rpu_attr_t            k_attr;
   rpu_attr_t            h_attr;
   rpu_attr_t            d_attr;
   rpu_attr_t            res_attr;
   rpu_attr_t            next_attr;
   logic                 next_valid;
   logic                 next_f1;
   logic                 next_f2;
   logic                 next_bg;

   // Reset release through two flops
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
            r[8*b +: 8] = wd[8*b +: 8];
      end
      return r;
   endfunction : be_merge

   // Unprivileged needs perm_lo, write needs perm_hi clear, fetch needs no_execute_flag clear
   function automatic logic perm_ok(input logic [31:0] bar, input logic priv, input logic wr,
                                    input logic fetch);
      return (priv | bar[`RPU_BAR_PERM_LO]) & ~(wr & bar[`RPU_BAR_PERM_HI])
             & ~(fetch & bar[`RPU_BAR_NOEXEC]);
   endfunction : perm_ok

   function automatic logic [7:0] pick_slot(input logic [31:0] lar, input logic [31:0] m0,
                                            input logic [31:0] m1);
      logic [2:0]  ix;
      logic [31:0] m;
      ix = lar[`RPU_LAR_IDX_HI:`RPU_LAR_IDX_LO];
      m  = ix[2] ? m1 : m0;
      return m[8*ix[1:0] +: 8];
   endfunction : pick_slot

   function automatic rpu_cache_t cmin(input rpu_cache_t a, input rpu_cache_t b);
      return (a < b) ? a : b;
   endfunction : cmin

   function automatic rpu_attr_t with_share(input rpu_attr_t a, input logic [1:0] dom);
      rpu_attr_t r;
      r = a;
      r.share = dom;
      if (a.dev || (a.inner == RPU_NC && a.outer == RPU_NC))
         r.share = `RPU_SHARE_OUTER;
      return r;
   endfunction : with_share

   function automatic rpu_attr_t combine(input rpu_attr_t a, input rpu_attr_t b);
      rpu_attr_t r;
      r = a;
      r.dev = a.dev | b.dev;
      if (a.dev && b.dev)
         r.dev_kind = (a.dev_kind < b.dev_kind) ? a.dev_kind : b.dev_kind;
      else
         r.dev_kind = a.dev ? a.dev_kind : b.dev_kind;
      r.inner       = r.dev ? RPU_NC : cmin(a.inner, b.inner);
      r.outer       = r.dev ? RPU_NC : cmin(a.outer, b.outer);
      r.inner_alloc = (r.inner == RPU_NC) ? 2'h0 : (a.inner_alloc & b.inner_alloc);
      r.outer_alloc = (r.outer == RPU_NC) ? 2'h0 : (a.outer_alloc & b.outer_alloc);
      if (a.share == `RPU_SHARE_OUTER || b.share == `RPU_SHARE_OUTER)
         r.share = `RPU_SHARE_OUTER;
      else if (a.share == `RPU_SHARE_INNER || b.share == `RPU_SHARE_INNER)
         r.share = `RPU_SHARE_INNER;
      else
         r.share = `RPU_SHARE_NON;
      return with_share(r, r.share);
   endfunction : combine

   // Register slave: one wait cycle, then accept
   always_comb
   begin
      bus_req          = avs_read | avs_write;
      bus_take         = bus_req & ~avs_waitrequest;
      next_waitrequest = ~(bus_req & avs_waitrequest);
      rgn_sel          = avs_address[7:3];
      rgn_ok           = (int'(rgn_sel) < NREG);
      rd_word          = 32'h0000_0000;
      unique case (avs_address[11:8])
         4'h0:
         begin
            unique case ({avs_address[7:2], 2'h0})
               8'(`RPU_OFF_CTRL):   rd_word = ctrl_reg;
               8'(`RPU_OFF_MTI0):   rd_word = mem_type_indirect_reg[0];
               8'(`RPU_OFF_MTI1):   rd_word = mem_type_indirect_reg[1];
               8'(`RPU_OFF_HMTI0):  rd_word = hyp_mem_type_indirect_reg[0];
               8'(`RPU_OFF_HMTI1):  rd_word = hyp_mem_type_indirect_reg[1];
               8'(`RPU_OFF_STATUS): rd_word = {29'h0000_0000, resp_fault_s2, resp_fault_s1, resp_background};
               8'(`RPU_OFF_FADDR):  rd_word = fault_addr;
               default:             rd_word = 32'h0000_0000;
            endcase
         end
         `RPU_PAGE_KREG:
         begin
            if (rgn_ok)
               rd_word = avs_address[2] ? region_limit_reg[rgn_sel] : region_base_reg[rgn_sel];
         end
         `RPU_PAGE_HREG:
         begin
            if (rgn_ok)
               rd_word = avs_address[2] ? hyp_region_limit_reg[rgn_sel] : hyp_region_base_reg[rgn_sel];
         end
         default: rd_word = 32'h0000_0000;
      endcase
      next_readdata = (avs_read & avs_waitrequest) ? rd_word : avs_readdata;
      next_ctrl_reg = ctrl_reg;
      next_mti      = mem_type_indirect_reg;
      next_hmti     = hyp_mem_type_indirect_reg;
      next_kbar     = region_base_reg;
      next_klar     = region_limit_reg;
      next_hbar     = hyp_region_base_reg;
      next_hlar     = hyp_region_limit_reg;
      if (bus_take && avs_write)
      begin
         if (avs_address[11:8] == 4'h0)
         begin
            unique case ({avs_address[7:2], 2'h0})
               8'(`RPU_OFF_CTRL):  next_ctrl_reg = be_merge(ctrl_reg, avs_writedata, avs_byteenable);
               8'(`RPU_OFF_MTI0):  next_mti[0]  = be_merge(next_mti[0], avs_writedata, avs_byteenable);
               8'(`RPU_OFF_MTI1):  next_mti[1]  = be_merge(next_mti[1], avs_writedata, avs_byteenable);
               8'(`RPU_OFF_HMTI0): next_hmti[0] = be_merge(next_hmti[0], avs_writedata, avs_byteenable);
               8'(`RPU_OFF_HMTI1): next_hmti[1] = be_merge(next_hmti[1], avs_writedata, avs_byteenable);
               default:            next_ctrl_reg = ctrl_reg;
            endcase
         end
         else if (avs_address[11:8] == `RPU_PAGE_KREG && rgn_ok)
         begin
            if (avs_address[2])
               next_klar[rgn_sel] = be_merge(region_limit_reg[rgn_sel], avs_writedata, avs_byteenable);
            else
               next_kbar[rgn_sel] = be_merge(region_base_reg[rgn_sel], avs_writedata, avs_byteenable);
         end
         else if (avs_address[11:8] == `RPU_PAGE_HREG && rgn_ok)
         begin
            if (avs_address[2])
               next_hlar[rgn_sel] = be_merge(hyp_region_limit_reg[rgn_sel], avs_writedata, avs_byteenable);
            else
               next_hbar[rgn_sel] = be_merge(hyp_region_base_reg[rgn_sel], avs_writedata, avs_byteenable);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         avs_waitrequest           <= 1'b1;
         avs_readdata              <= `RPU_RST_WORD;
         ctrl_reg                  <= `RPU_RST_WORD;
         mem_type_indirect_reg     <= '{default: `RPU_RST_WORD};
         hyp_mem_type_indirect_reg <= '{default: `RPU_RST_WORD};
         region_base_reg           <= '0;
         region_limit_reg          <= '0;
         hyp_region_base_reg       <= '0;
         hyp_region_limit_reg      <= '0;
      end
      else
      begin
         avs_waitrequest           <= next_waitrequest;
         avs_readdata              <= next_readdata;
         ctrl_reg                  <= next_ctrl_reg;
         mem_type_indirect_reg     <= next_mti;
         hyp_mem_type_indirect_reg <= next_hmti;
         region_base_reg           <= next_kbar;
         region_limit_reg          <= next_klar;
         hyp_region_base_reg       <= next_hbar;
         hyp_region_limit_reg      <= next_hlar;
      end
   end

   rpu_region_match #(.NREG(NREG), .IW(IW)) u_kmatch (
      .addr  (req_addr),
      .base  (region_base_reg),
      .limit (region_limit_reg),
      .hit   (k_hit),
      .idx   (k_idx)
   );

   rpu_region_match #(.NREG(NREG), .IW(IW)) u_hmatch (
      .addr  (req_addr),
      .base  (hyp_region_base_reg),
      .limit (hyp_region_limit_reg),
      .hit   (h_hit),
      .idx   (h_idx)
   );

   always_comb
   begin
      k_bar  = region_base_reg[k_idx];
      k_lar  = region_limit_reg[k_idx];
      h_bar  = hyp_region_base_reg[h_idx];
      h_lar  = hyp_region_limit_reg[h_idx];
      k_slot = pick_slot(k_lar, mem_type_indirect_reg[0], mem_type_indirect_reg[1]);
      h_slot = pick_slot(h_lar, hyp_mem_type_indirect_reg[0], hyp_mem_type_indirect_reg[1]);
      d_slot = (req_addr[31:30] == 2'h3) ? `RPU_DFLT_DEV_NE :
               (req_addr[31:30] == 2'h2) ? `RPU_DFLT_DEV_E : `RPU_DFLT_NORMAL;
   end

   rpu_attr_decode u_kdec (
      .slot        (k_slot),
      .dev         (k_attr.dev),
      .dev_kind    (k_attr.dev_kind),
      .inner       (k_attr.inner),
      .outer       (k_attr.outer),
      .inner_alloc (k_attr.inner_alloc),
      .outer_alloc (k_attr.outer_alloc)
   );
   assign k_attr.share = k_bar[`RPU_BAR_DOM_HI:`RPU_BAR_DOM_LO];

   rpu_attr_decode u_hdec (
      .slot        (h_slot),
      .dev         (h_attr.dev),
      .dev_kind    (h_attr.dev_kind),
      .inner       (h_attr.inner),
      .outer       (h_attr.outer),
      .inner_alloc (h_attr.inner_alloc),
      .outer_alloc (h_attr.outer_alloc)
   );
   assign h_attr.share = h_bar[`RPU_BAR_DOM_HI:`RPU_BAR_DOM_LO];

   rpu_attr_decode u_ddec (
      .slot        (d_slot),
      .dev         (d_attr.dev),
      .dev_kind    (d_attr.dev_kind),
      .inner       (d_attr.inner),
      .outer       (d_attr.outer),
      .inner_alloc (d_attr.inner_alloc),
      .outer_alloc (d_attr.outer_alloc)
   );
   assign d_attr.share = `RPU_SHARE_OUTER;

   // Access check; answer registered one cycle after the request
   always_comb
   begin
      logic priv;
      logic dflt_ok;
      priv     = (req_tier != RPU_UNPRIV);
      dflt_ok  = ~(req_fetch & req_addr[31]);
      next_f1  = 1'b0;
      next_f2  = 1'b0;
      next_bg  = 1'b0;
      res_attr = d_attr;
      if (req_tier == RPU_HYP)
      begin
         if (!ctrl_reg[`RPU_CTRL_H_EN] || (!h_hit && ctrl_reg[`RPU_CTRL_H_BG]))
         begin
            next_bg = 1'b1;
            next_f1 = ~dflt_ok;
         end
         else if (h_hit)
         begin
            res_attr = with_share(h_attr, h_attr.share);
            next_f1  = ~perm_ok(h_bar, priv, req_write, req_fetch);
         end
         else
            next_f1 = 1'b1;
      end
      else
      begin
         if (!ctrl_reg[`RPU_CTRL_K_EN] || (!k_hit && priv && ctrl_reg[`RPU_CTRL_K_BG]))
         begin
            next_bg = 1'b1;
            next_f1 = ~dflt_ok;
         end
         else if (k_hit)
         begin
            res_attr = with_share(k_attr, k_attr.share);
            next_f1  = ~perm_ok(k_bar, priv, req_write, req_fetch);
         end
         else
            next_f1 = 1'b1;
         if (ctrl_reg[`RPU_CTRL_S2_EN] && ctrl_reg[`RPU_CTRL_H_EN])
         begin
            next_f2  = ~next_f1 & ~(h_hit && perm_ok(h_bar, priv, req_write, req_fetch));
            res_attr = combine(res_attr, h_attr);
         end
      end
      next_valid      = req_valid;
      next_attr       = res_attr;
      next_fault_addr = (req_valid && (next_f1 || next_f2)) ? req_addr : fault_addr;
   end

   always_ff @(posedge clock or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         resp_valid       <= 1'b0;
         resp_paddr       <= `RPU_RST_WORD;
         resp_fault_s1    <= 1'b0;
         resp_fault_s2    <= 1'b0;
         resp_background  <= 1'b0;
         resp_device      <= 1'b0;
         resp_dev_kind    <= 2'h0;
         resp_inner       <= RPU_NC;
         resp_outer       <= RPU_NC;
         resp_inner_alloc <= 2'h0;
         resp_outer_alloc <= 2'h0;
         resp_share       <= `RPU_SHARE_NON;
         fault_addr       <= `RPU_RST_WORD;
      end
      else
      begin
         resp_valid       <= next_valid;
         resp_paddr       <= req_addr;
         resp_fault_s1    <= next_f1;
         resp_fault_s2    <= next_f2;
         resp_background  <= next_bg;
         resp_device      <= next_attr.dev;
         resp_dev_kind    <= next_attr.dev_kind;
         resp_inner       <= next_attr.inner;
         resp_outer       <= next_attr.outer;
         resp_inner_alloc <= next_attr.inner_alloc;
         resp_outer_alloc <= next_attr.outer_alloc;
         resp_share       <= next_attr.share;
         fault_addr       <= next_fault_addr;
      end
   end

endmodule : rpu_top

// ==== rpu_top_assertions.sv ====
/* Checker for rpu_top: bus accept timing, response timing, attribute consistency.
   Assumes one clock domain. */
`timescale 1ns/1ps
module rpu_top_assertions (
   input wire logic                clock,
   input wire logic                rst_b,
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic                avs_waitrequest,
   input wire logic                req_valid,
   input wire logic [31:0]         req_addr,
   input wire logic                resp_valid,
   input wire logic [31:0]         resp_paddr,
   input wire logic                resp_fault_s1,
   input wire logic                resp_fault_s2,
   input wire logic                resp_device,
   input wire logic [1:0]          resp_dev_kind,
   input wire rpu_pkg::rpu_cache_t resp_inner,
   input wire rpu_pkg::rpu_cache_t resp_outer,
   input wire logic [1:0]          resp_inner_alloc,
   input wire logic [1:0]          resp_share
);
   import rpu_pkg::*;
   wire ok = resp_valid && !resp_fault_s1 && !resp_fault_s2;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_acc; !avs_waitrequest ##1 avs_waitrequest; endsequence
   property p_accept; s_req |=> s_acc; endproperty
   a_accept: assert property (p_accept) else $error("bus accept not one cycle after request");
   property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("waitrequest low without request");
   property p_paddr; req_valid |=> resp_valid && resp_paddr == $past(req_addr); endproperty
   a_paddr: assert property (p_paddr) else $error("response address differs from request");
   property p_novalid; !req_valid |=> !resp_valid; endproperty
   a_novalid: assert property (p_novalid) else $error("response without request");
   property p_excl; !(resp_fault_s1 && resp_fault_s2); endproperty
   a_excl: assert property (p_excl) else $error("both stage faults at once");
   property p_share; ok && (resp_device || resp_inner == RPU_NC && resp_outer == RPU_NC) |-> resp_share == 2'h2;
   endproperty
   a_share: assert property (p_share) else $error("device or non-cacheable not outer shareable");
   property p_alloc; ok && resp_inner == RPU_NC |-> resp_inner_alloc == 2'h0; endproperty
   a_alloc: assert property (p_alloc) else $error("allocate hint on non-cacheable");
   property p_kind; ok && !resp_device |-> resp_dev_kind == 2'h0; endproperty
   a_kind: assert property (p_kind) else $error("device kind on normal memory");
endmodule : rpu_top_assertions
bind rpu_top rpu_top_assertions u_chk (.*);

// ==== rpu_top_test.sv ====
/* Bench for rpu_top: registers over Avalon-MM, core requests through the core model.
   Assumes the other files compile first. */
`timescale 1ns/1ps
module rpu_top_test;
   import rpu_pkg::*;
   logic        clock = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, go = 1'b0;
   logic        go_write = 1'b0, go_fetch = 1'b0, req_valid, req_write, req_fetch, avs_waitrequest;
   logic        resp_valid, resp_fault_s1, resp_fault_s2, resp_background, resp_device;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [11:0] avs_address = 12'h000;
   logic [31:0] avs_writedata = 32'h0000_0000, go_addr = 32'h0000_0000, req_addr, avs_readdata, resp_paddr, a;
   logic [1:0]  go_tier = 2'h0, resp_dev_kind, resp_inner_alloc, resp_outer_alloc, resp_share;
   rpu_tier_t   req_tier;
   rpu_cache_t  resp_inner, resp_outer;
   logic [46:0] nq[$], n;
   logic [45:0] m;
   logic [31:0] rq[$];
   int          errors = 0, cmp_count = 0;
   rpu_top #(.NREG(8)) dut (.*);
   rpu_core_model core (.*);
   initial forever #25 clock = ~clock;
   task automatic fail(input string s);
      errors++;
      $display("CHECK FAILED %0t %s", $time, s);
   endtask : fail
   task automatic bus(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask : bus
   task automatic rd(input logic [11:0] ad, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, ad, 32'h0000_0000);
   endtask : rd
   // Code: dev, kind, inner, outer, share, alloc (inner=outer); fo: address and faults only
   task automatic chk(input logic [31:0] ad, input logic [1:0] t, input logic w, f, input logic [2:0] s,
                      input logic [10:0] at, input logic fo);
      nq.push_back({fo, ad, s, at});
      go <= 1'b1;
      go_addr <= ad;
      go_tier <= t;
      go_write <= w;
      go_fetch <= f;
      @(posedge clock);
   endtask : chk
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test
   always @(negedge clock)
      if (resp_valid === 1'b1)
      begin
         n = nq.pop_front();
         m = n[46] ? 46'h3FFF_FFFF_F000 : '1;
         cmp_count++;
         if (({resp_paddr, resp_fault_s1, resp_fault_s2, resp_background, resp_device, resp_dev_kind, resp_inner,
               resp_outer, resp_share, resp_inner_alloc} & m) !== (n[45:0] & m)
               || !n[46] && resp_outer_alloc !== n[1:0]) fail("core response");
      end
   always @(posedge clock)
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      begin
         cmp_count++;
         if (avs_readdata !== rq.pop_front()) fail("read data");
      end
   initial
   begin
      #(50 * 5000);
      fail("timeout");
      end_of_test();
   end
   initial
   begin
      void'($urandom(32'h7a4f_e8c8));
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      rd(12'h000, 32'h0000_0000);
      rd(12'h104, 32'h0000_0000);
      bus(1'b1, 12'h7F0, 32'h1234_5678);
      rd(12'h7F0, 32'h0000_0000);
      repeat (16)
      begin
         a = $urandom();
         chk(a, 2'($urandom_range(2)), 1'($urandom()), !a[31] && 1'($urandom()), 3'h1,
             a[31] ? (a[30] ? 11'h408 : 11'h508) : 11'h008, 1'b0);
      end
      go <= 1'b0;
      $display("test default map done");
      bus(1'b1, 12'h004, 32'h0000_0004);
      bus(1'b1, 12'h008, 32'h0000_FF00);
      bus(1'b1, 12'h100, 32'h0001_001F);
      bus(1'b1, 12'h104, 32'h0001_00CB);
      bus(1'b1, 12'h108, 32'h0002_001A);
      bus(1'b1, 12'h10C, 32'h0002_0001);
      bus(1'b1, 12'h000, 32'h0000_0001);
      rd(12'h100, 32'h0001_001F);
      chk(32'h0001_0000, 2'h1, 1'b0, 1'b0, 3'h0, 11'h0AF, 1'b0);
      chk(32'h0001_00FF, 2'h1, 1'b0, 1'b0, 3'h0, 11'h0AF, 1'b0);
      chk(32'h0001_0100, 2'h1, 1'b0, 1'b0, 3'h4, 11'h000, 1'b1);
      chk(32'h0000_FFFF, 2'h1, 1'b0, 1'b0, 3'h4, 11'h000, 1'b1);
      chk(32'h0001_0040, 2'h1, 1'b1, 1'b0, 3'h4, 11'h000, 1'b1);
      chk(32'h0001_0080, 2'h1, 1'b0, 1'b1, 3'h4, 11'h000, 1'b1);
      chk(32'h0001_0080, 2'h0, 1'b0, 1'b1, 3'h4, 11'h000, 1'b1);
      chk(32'h0002_0000, 2'h1, 1'b0, 1'b1, 3'h0, 11'h508, 1'b0);
      chk(32'h0002_003F, 2'h0, 1'b0, 1'b0, 3'h0, 11'h508, 1'b0);
      chk(32'h0002_0040, 2'h0, 1'b0, 1'b0, 3'h4, 11'h000, 1'b1);
      chk(32'h0001_0000, 2'h2, 1'b0, 1'b0, 3'h1, 11'h008, 1'b0);
      go <= 1'b0;
      $display("test kernel regions done");
      bus(1'b1, 12'h200, 32'h0000_0004);
      bus(1'b1, 12'h204, 32'h0003_FFC1);
      bus(1'b1, 12'h00C, 32'h0000_00AA);
      bus(1'b1, 12'h000, 32'h0000_0007);
      chk(32'h0001_0000, 2'h1, 1'b0, 1'b0, 3'h0, 11'h05E, 1'b0);
      chk(32'h0002_0000, 2'h1, 1'b1, 1'b0, 3'h2, 11'h000, 1'b1);
      chk(32'h0003_0000, 2'h1, 1'b0, 1'b0, 3'h4, 11'h000, 1'b1);
      chk(32'h0002_003F, 2'h1, 1'b0, 1'b0, 3'h0, 11'h508, 1'b0);
      chk(32'h0000_1000, 2'h2, 1'b0, 1'b0, 3'h0, 11'h052, 1'b0);
      go <= 1'b0;
      bus(1'b1, 12'h000, 32'h0000_0006);
      chk(32'h0002_0040, 2'h0, 1'b0, 1'b0, 3'h2, 11'h000, 1'b1);
      go <= 1'b0;
      repeat (4) @(posedge clock);
      $display("test stage two done");
      end_of_test();
   end
endmodule : rpu_top_test
